//--- core/asbp_pkg.sv
// Package for the byte-wide asynchronous static RAM host controller.
package asbp_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_PS = 4000;

	// Device timing in picoseconds, slowest speed grade.
	localparam int ADDR_ACCESS_PS = 15000;
	localparam int WRITE_PULSE_PS = 10000;
	localparam int WRITE_FLOAT_DELAY_PS = 8000;
	localparam int DATA_OVERLAP_MIN_PS = 8000;
	localparam int OUTPUT_FLOAT_PS = 7000;

	// Least times round up to whole cycles.
	localparam int READ_CYC = (ADDR_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
	localparam int WP_MIN_PS = (WRITE_PULSE_PS > WRITE_FLOAT_DELAY_PS + DATA_OVERLAP_MIN_PS)
		? WRITE_PULSE_PS : WRITE_FLOAT_DELAY_PS + DATA_OVERLAP_MIN_PS + 1;
	localparam int WRITE_CYC = (WP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FLOAT_CYC = (WRITE_FLOAT_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TURN_CYC = (OUTPUT_FLOAT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 4;

	typedef struct packed {
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} asbp_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] word_address_lines;
		logic select_active_low_n;
		logic select_active_high;
		logic write_strobe_n;
		logic output_drive_n;
	} asbp_pins_t;

	localparam asbp_pins_t PINS_IDLE = '{
		word_address_lines: 16'h0000,
		select_active_low_n: 1'b1,
		select_active_high: 1'b0,
		write_strobe_n: 1'b1,
		output_drive_n: 1'b1
	};

endpackage : asbp_pkg

//--- core/asbp_sync.sv
// Two-flop synchroniser for the byte lines read back from the RAM.
`timescale 1ns/100ps
module asbp_sync #(
	parameter int W = 8
) (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// Data.
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			s1_q <= '0;
			s2_q <= '0;
		end
		else
		begin
			s1_q <= d_i;
			s2_q <= s1_q;
		end
	end

	assign q_o = s2_q;

endmodule : asbp_sync

//--- core/asbp_ctrl.sv
// Host controller driving a byte-wide asynchronous static RAM through its pins.
`timescale 1ns/100ps
// Functional notes
// - Host presents a sixteen-bit address, one byte per address.
// - Eight shared byte lines: RAM drives on reads, host on writes.
// - Address changes only while strobe or low select is high.
// - Strobe pulse exceeds float delay plus data overlap time.
// - Host never drives byte lines while the RAM drives them.
module asbp_ctrl
	import asbp_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic srst_i,
	// User request side.
	input wire logic req_valid_i,
	input wire asbp_pkg::asbp_req_t req_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [asbp_pkg::DATA_W-1:0] rsp_rdata_o,
	// RAM pins.
	output asbp_pkg::asbp_pins_t pins_o,
	input wire logic [asbp_pkg::DATA_W-1:0] byte_lines_i,
	output logic [asbp_pkg::DATA_W-1:0] byte_lines_o,
	output logic byte_lines_oe_o
);
	import asbp_pkg::*;

	// The counters must reach every terminal count without wrapping.
	if (READ_CYC + 2 >= (1 << CNT_W))
	begin : g_read_cnt_check
		$error("Read access count exceeds counter width.");
	end
	if (WRITE_CYC + 1 >= (1 << CNT_W))
	begin : g_write_cnt_check
		$error("Write pulse count exceeds counter width.");
	end
	// A turnaround of zero cycles would let the next write meet a driving RAM.
	if (TURN_CYC < 1 || TURN_CYC >= (1 << CNT_W))
	begin : g_turn_cnt_check
		$error("Turnaround count outside the counter range.");
	end
	// The strobe pulse has to outlast the float delay plus the data overlap.
	if (WRITE_CYC * CLK_PERIOD_PS <= WRITE_FLOAT_DELAY_PS + DATA_OVERLAP_MIN_PS)
	begin : g_pulse_check
		$error("Write pulse too short for the RAM to release its drivers.");
	end
	// Read data are sampled a whole number of cycles after the address moves.
	if (READ_CYC * CLK_PERIOD_PS < ADDR_ACCESS_PS)
	begin : g_access_check
		$error("Read sampling comes before the access time.");
	end

	typedef enum logic [2:0] {
		ST_IDLE, ST_RD, ST_RD_WAIT, ST_WR_SETUP, ST_WR, ST_WR_END, ST_TURN
	} asbp_state_t;

	asbp_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	asbp_pins_t pins_q, pins_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic oe_q, oe_d;
	logic ready_q, ready_d;
	logic rsp_valid_q, rsp_valid_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic [DATA_W-1:0] rd_sync;

	asbp_sync #(
		.W(DATA_W)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.d_i(byte_lines_i),
		.q_o(rd_sync)
	);

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		pins_d = pins_q;
		wdata_d = wdata_q;
		oe_d = oe_q;
		ready_d = 1'b0;
		rsp_valid_d = 1'b0;
		rdata_d = rdata_q;
		unique case (state_q)
			ST_IDLE:
			begin
				ready_d = 1'b1;
				if (req_valid_i && ready_q)
				begin
					ready_d = 1'b0;
					// Address moves only with the strobe high; a read drops low select on the same edge.
					pins_d.word_address_lines = req_i.addr;
					pins_d.select_active_high = 1'b1;
					cnt_d = '0;
					if (req_i.wr)
					begin
						wdata_d = req_i.wdata;
						// Drive enable stays high so the RAM never drives.
						pins_d.output_drive_n = 1'b1;
						state_d = ST_WR_SETUP;
					end
					else
					begin
						// Both selects on, drive enable low, strobe high.
						pins_d.select_active_low_n = 1'b0;
						pins_d.output_drive_n = 1'b0;
						state_d = ST_RD;
					end
				end
			end
			ST_RD:
			begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(READ_CYC - 1))
				begin
					cnt_d = '0;
					state_d = ST_RD_WAIT;
				end
			end
			ST_RD_WAIT:
			begin
				// Wait out the synchroniser before sampling.
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(1))
				begin
					rdata_d = rd_sync;
					rsp_valid_d = 1'b1;
					pins_d = PINS_IDLE;
					pins_d.word_address_lines = pins_q.word_address_lines;
					cnt_d = '0;
					state_d = ST_TURN;
				end
			end
			ST_WR_SETUP:
			begin
				// Strobe and low select fall together, so RAM outputs stay floating.
				pins_d.write_strobe_n = 1'b0;
				pins_d.select_active_low_n = 1'b0;
				oe_d = 1'b1;
				state_d = ST_WR;
			end
			ST_WR:
			begin
				// Write pulse spans the float delay plus data overlap.
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(WRITE_CYC - 1))
				begin
					pins_d.write_strobe_n = 1'b1;
					pins_d.select_active_low_n = 1'b1;
					cnt_d = '0;
					state_d = ST_WR_END;
				end
			end
			ST_WR_END:
			begin
				// Data held one cycle past the strobe's rise.
				oe_d = 1'b0;
				pins_d.select_active_high = 1'b0;
				rsp_valid_d = 1'b1;
				state_d = ST_TURN;
			end
			ST_TURN:
			begin
				// Bus turnaround so RAM drivers release before the next cycle.
				// The RAM lets go of the byte lines within its float time after deselect.
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= CNT_W'(TURN_CYC - 1))
				begin
					cnt_d = '0;
					ready_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
		begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			pins_q <= PINS_IDLE;
			wdata_q <= '0;
			oe_q <= 1'b0;
			ready_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rdata_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			pins_q <= pins_d;
			wdata_q <= wdata_d;
			oe_q <= oe_d;
			ready_q <= ready_d;
			rsp_valid_q <= rsp_valid_d;
			rdata_q <= rdata_d;
		end
	end

	assign pins_o = pins_q;
	assign byte_lines_o = wdata_q;
	assign byte_lines_oe_o = oe_q;
	assign req_ready_o = ready_q;
	assign rsp_valid_o = rsp_valid_q;
	assign rsp_rdata_o = rdata_q;

endmodule : asbp_ctrl

//--- test/asbp_props.sv
// Checker for the static RAM host controller's pin sequencing.
`timescale 1ns/100ps
module asbp_props
	import asbp_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic req_valid_i,
	input wire logic req_ready_o,
	input wire logic rsp_valid_o,
	input wire asbp_pkg::asbp_pins_t pins_o,
	input wire logic [asbp_pkg::DATA_W-1:0] byte_lines_o,
	input wire logic byte_lines_oe_o
);
	wire ws = pins_o.write_strobe_n;
	wire ls = pins_o.select_active_low_n;
	// Checks stay off for one edge after release, so history starts at reset values.
	logic rst_q;
	always_ff @(posedge ref_clk_i)
		rst_q <= srst_i;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (srst_i || rst_q);
	a_no_contention: assert property (byte_lines_oe_o |-> pins_o.output_drive_n)
		else $error("host drives while RAM may drive");
	a_addr_hold: assert property ($changed(pins_o.word_address_lines) |->
		(ws || ls) && ($past(ws) || $past(ls)))
		else $error("address moved inside a write");
	a_pulse_width: assert property ($fell(ws) |-> !ws [*5] ##1 ws)
		else $error("strobe pulse not five cycles");
	a_strobe_select: assert property ($fell(ws) |-> $fell(ls) && pins_o.output_drive_n)
		else $error("select did not fall with strobe");
	a_write_drive: assert property (!ws |-> byte_lines_oe_o ##1 (ws || $stable(byte_lines_o)))
		else $error("write data not held");
	a_write_done: assert property ($rose(ws) |-> ##1 rsp_valid_o && !byte_lines_oe_o)
		else $error("write end not answered");
	a_read_answer: assert property ($fell(pins_o.output_drive_n) |-> ##7 rsp_valid_o)
		else $error("read answer late or early");
	a_turn_gap: assert property (rsp_valid_o |-> !req_ready_o [*2])
		else $error("turnaround too short");
	c_write: cover property ($fell(ws));
	c_read: cover property ($fell(pins_o.output_drive_n));
	c_next: cover property (rsp_valid_o ##3 req_valid_i && req_ready_o);
endmodule : asbp_props
bind asbp_ctrl asbp_props chk (.ref_clk_i, .srst_i, .req_valid_i, .req_ready_o, .rsp_valid_o,
	.pins_o, .byte_lines_o, .byte_lines_oe_o);

//--- test/asbp_ram_model.sv
// Behavioural byte-wide static RAM seen from its pins.
`timescale 1ns/100ps
module asbp_ram_model
	import asbp_pkg::*;
#(
	parameter int DLY_NS = 7
) (
	// Pins.
	input wire asbp_pkg::asbp_pins_t pins_i,
	input wire logic [7:0] bus_i,
	output logic [7:0] q_o,
	output logic oe_o
);
	logic [7:0] mem [0:65535];
	wire on = !pins_i.select_active_low_n && pins_i.select_active_high;
	wire rd = on && !pins_i.output_drive_n && pins_i.write_strobe_n;
	assign #DLY_NS oe_o = rd;
	assign #DLY_NS q_o = mem[pins_i.word_address_lines];
	always @*
		if (on && !pins_i.write_strobe_n)
			mem[pins_i.word_address_lines] = bus_i;
endmodule : asbp_ram_model

//--- test/testbench.sv
// Self-checking bench for the static RAM host controller.
`timescale 1ns/100ps
module testbench;
	import asbp_pkg::*;
	logic ref_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic req_valid_i = 1'b0;
	asbp_req_t req_i = '0;
	logic req_ready_o, rsp_valid_o, byte_lines_oe_o, ram_oe;
	logic [7:0] rsp_rdata_o, byte_lines_o, ram_q;
	logic [7:0] last_q = 8'hA5;
	logic [31:0] seed = 32'hB877;
	logic [15:0] a;
	logic [7:0] shadow [logic [15:0]];
	asbp_pins_t pins_o;
	int miscompares = 0;
	int tests_run = 0;
	// An undriven wire shows the inverse of its last level.
	wire [7:0] bl = byte_lines_oe_o ? byte_lines_o : ram_oe ? ram_q : ~last_q;
	always @(posedge ref_clk_i) last_q <= bl;
	initial forever #2 ref_clk_i = ~ref_clk_i;
	asbp_ctrl dut (.ref_clk_i, .srst_i, .req_valid_i, .req_i, .req_ready_o, .rsp_valid_o,
		.rsp_rdata_o, .pins_o, .byte_lines_i(bl), .byte_lines_o, .byte_lines_oe_o);
	asbp_ram_model ram (.pins_i(pins_o), .bus_i(bl), .q_o(ram_q), .oe_o(ram_oe));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic complete_run;
		$display("%0d compared, %0d wrong", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic wait_for(ref logic s);
		int n;
		n = 0;
		do
		begin
			@(negedge ref_clk_i);
			n++;
		end
		while (s !== 1'b1 && n < 40);
		check("wait bound", 8'h00, 8'(n / 40));
		if (n >= 40)
			complete_run();
	endtask : wait_for
	task automatic xfer(input logic w, input logic [15:0] ad, input logic [7:0] d);
		wait_for(req_ready_o);
		@(posedge ref_clk_i);
		req_valid_i <= 1'b1;
		req_i <= '{wr: w, addr: ad, wdata: d};
		@(posedge ref_clk_i);
		req_valid_i <= 1'b0;
		wait_for(rsp_valid_o);
		if (w)
			shadow[ad] = d;
		else
			check("read byte", shadow[ad], rsp_rdata_o);
	endtask : xfer
	initial
	begin
		@(posedge ref_clk_i);
		@(negedge ref_clk_i);
		check("idle pins", 8'h0B, {3'h0, byte_lines_oe_o, 4'(pins_o[3:0])});
		@(posedge ref_clk_i);
		srst_i <= 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			a = i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : 16'h8001;
			xfer(1'b1, a, a[7:0] ^ 8'h5A);
			xfer(1'b0, a, 8'h00);
		end
		$display("corner test done");
		for (int i = 0; i < 60; i++)
		begin
			seed = lfsr(seed);
			a = {seed[20], 11'h000, seed[3:0]};
			xfer(!shadow.exists(a) || seed[8], a, seed[31:24]);
		end
		$display("random test done");
		@(posedge ref_clk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		@(negedge ref_clk_i);
		check("reset pins", 8'h0B, {3'h0, byte_lines_oe_o, 4'(pins_o[3:0])});
		xfer(1'b0, 16'hFFFF, 8'h00);
		$display("reset test done");
		complete_run();
	end
endmodule : testbench
